/* brwa_alarm_mem.sv */
// Purpose: Alarm time store, eight bytes, registered read port
// Assumes: Written by the bus slave only
// Notes:   Flat view feeds the comparator in parallel
`timescale 1ns/10ps
module brwa_alarm_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [7:0]  wdata,
  // Read port
  input  wire logic [2:0]  raddr,
  output logic      [7:0]  rdata_q,
  // Parallel view
  output logic      [63:0] flat
);

  logic [7:0] mem_q [8];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      flat[8*i +: 8] = mem_q[i];
    end
  end

endmodule : brwa_alarm_mem

/* brwa_host_model.sv */
// Purpose: Host processor model, Wishbone master and strobe pin
// Assumes: Tasks are called one at a time
// Notes:   Released data is inverted so stale bytes never match
`timescale 1ns/10ps
module brwa_host_model
  import brwa_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [31:0] adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack,
  // Strobe pin
  output logic             ale
);
  initial begin
    {cyc, stb, we, adr, dat_w} = '0;
    sel = 4'h1;
    ale = 1'b1;
  end
  task automatic access(input logic w, input logic [4:0] i, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {25'h0, i, 2'h0};
    dat_w <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc   <= 1'b0;
    stb   <= 1'b0;
    dat_w <= ~dat_w;
  endtask : access
  // Hundredths first, so later reads see one time
  task automatic snap();
    logic [7:0] q;
    access(1'b0, IDX_HUND, 8'h00, q);
  endtask : snap
  // Held three cycles to cross the pin synchroniser
  task automatic set_ale(input logic lvl, input logic [4:0] i);
    @(posedge clk);
    adr <= {25'h0, i, 2'h0};
    ale <= lvl;
    repeat (3) @(posedge clk);
  endtask : set_ale
  // Byte select for the accesses that follow
  task automatic set_sel(input logic [3:0] s);
    @(posedge clk);
    sel <= s;
  endtask : set_sel
endmodule : brwa_host_model

/* brwa_pkg.sv */
// Purpose: Shared constants for the bus real-time clock with alarm
// Assumes: Classic Wishbone, 32-bit words, 8-bit data in the low byte
// Notes:   Byte address of a register is four times its index
package brwa_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [4:0] IDX_HUND   = 5'h00;
  localparam logic [4:0] IDX_HOUR   = 5'h01;
  localparam logic [4:0] IDX_MIN    = 5'h02;
  localparam logic [4:0] IDX_SEC    = 5'h03;
  localparam logic [4:0] IDX_MONTH  = 5'h04;
  localparam logic [4:0] IDX_DATE   = 5'h05;
  localparam logic [4:0] IDX_YEAR   = 5'h06;
  localparam logic [4:0] IDX_DAY    = 5'h07;
  localparam logic [4:0] IDX_ALM0   = 5'h08;
  localparam logic [4:0] IDX_ALM7   = 5'h0f;
  localparam logic [4:0] IDX_STATUS = 5'h10;
  localparam logic [4:0] IDX_MASK   = 5'h11;
  localparam logic [4:0] IDX_CMD    = 5'h12;
  localparam logic [4:0] IDX_POWER  = 5'h13;
  localparam int         ADR_LSB    = 2;
  localparam int         IDX_W      = 5;

  // Status and mask layout
  localparam int ST_ALARM = 0;
  localparam int ST_P100  = 1;
  localparam int ST_P10   = 2;
  localparam int ST_P1S   = 3;
  localparam int ST_PMIN  = 4;
  localparam int ST_PHOUR = 5;
  localparam int ST_PDAY  = 6;
  localparam int ST_W     = 7;

  // Command layout
  localparam int CMD_XTAL_LO = 0;
  localparam int CMD_XTAL_HI = 1;
  localparam int CMD_H24     = 2;
  localparam int CMD_RUN     = 3;
  localparam int CMD_W       = 4;
  localparam logic [3:0] CMD_RESET = 4'h0;

  // Hour byte layout in 12-hour format
  localparam int HOUR_PM = 7;

  // Crystal frequencies in Hz, and the counting rate
  localparam int XTAL_F0  = 32768;
  localparam int XTAL_F1  = 1048576;
  localparam int XTAL_F2  = 2097152;
  localparam int XTAL_F3  = 4194304;
  localparam int TICK_HZ  = 100;
  localparam int ACC_W    = 23;

  // Counter limits and reset values
  localparam logic [6:0] HUND_MAX  = 7'd99;
  localparam logic [5:0] SEC_MAX   = 6'd59;
  localparam logic [5:0] MIN_MAX   = 6'd59;
  localparam logic [4:0] HOUR_MAX  = 5'd23;
  localparam logic [3:0] MONTH_MAX = 4'd12;
  localparam logic [6:0] YEAR_MAX  = 7'd99;
  localparam logic [2:0] DAY_MAX   = 3'd6;
  localparam logic [4:0] DATE_RST  = 5'd1;
  localparam logic [3:0] MONTH_RST = 4'd1;
  localparam logic [3:0] FEB       = 4'd2;

  // Width mask of each time field, by index 0..7
  function automatic logic [7:0] field_mask(input logic [2:0] i);
    case (i)
      3'd0:    field_mask = 8'h7f;
      3'd1:    field_mask = 8'h9f;
      3'd2:    field_mask = 8'h3f;
      3'd3:    field_mask = 8'h3f;
      3'd4:    field_mask = 8'h0f;
      3'd5:    field_mask = 8'h1f;
      3'd6:    field_mask = 8'h7f;
      default: field_mask = 8'h07;
    endcase
  endfunction : field_mask

endpackage : brwa_pkg

/* brwa_top.sv */
// Purpose: Real-time clock with calendar, alarm and periodic interrupts
// Assumes: Classic Wishbone master on clk; osc, ale, power_fail are pins
// Notes:   Osc edges must be well below half the clk rate
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module brwa_top
  import brwa_pkg::*;
#(
  parameter int F0 = XTAL_F0,
  parameter int F1 = XTAL_F1,
  parameter int F2 = XTAL_F2,
  parameter int F3 = XTAL_F3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic        osc_i,
  input  wire logic        ale_i,
  input  wire logic        power_fail_i,
  // Interrupt
  output logic             irq_o
);

  // Time counters
  logic [6:0] hund_q;
  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic [4:0] hour_q;
  logic [4:0] date_q;
  logic [3:0] month_q;
  logic [6:0] year_q;
  logic [2:0] day_q;
  logic [7:0] snap_q [8];

  // Control and status
  logic [CMD_W-1:0] cmd_q;
  logic [ST_W-1:0]  status_q;
  logic [ST_W-1:0]  mask_q;
  logic [ST_W-1:0]  ev;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] freq;
  logic [2:0]       osc_s_q;
  logic [1:0]       ale_s_q;
  logic [1:0]       pf_s_q;
  logic             tick;
  logic             step;
  logic             chk_q;
  logic             pend_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             acc_go;
  logic             wr_go;
  logic             rd_go;
  logic [7:0]       wbyte;
  logic [7:0]       rbyte;
  logic [7:0]       alm_rd;
  logic [63:0]      alm_flat;
  logic [63:0]      live_flat;
  logic             alm_hit;
  logic             st_read;
  logic             backup;

  function automatic logic [7:0] to_12h(input logic [4:0] h, input logic h24);
    logic [4:0] h12;
    h12 = 5'd0;
    if (h24) begin
      to_12h = {3'b000, h};
    end else begin
      if (h == 5'd0) begin
        h12 = 5'd12;
      end else if (h > 5'd12) begin
        h12 = h - 5'd12;
      end else begin
        h12 = h;
      end
      to_12h = {(h >= 5'd12), 2'b00, h12};
    end
  endfunction : to_12h

  function automatic logic [4:0] from_12h(input logic [7:0] b, input logic h24);
    logic [4:0] h;
    h = b[4:0];
    if (h24) begin
      from_12h = h;
    end else begin
      if (h == 5'd12) begin
        h = 5'd0;
      end
      from_12h = b[HOUR_PM] ? h + 5'd12 : h;
    end
  endfunction : from_12h

  function automatic logic [4:0] month_days(input logic [3:0] m, input logic leap);
    case (m)
      4'd2:                      month_days = leap ? 5'd29 : 5'd28;
      4'd4, 4'd6, 4'd9, 4'd11:   month_days = 5'd30;
      default:                   month_days = 5'd31;
    endcase
  endfunction : month_days

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_s_q <= 3'b000;
      ale_s_q <= 2'b11;
      pf_s_q  <= 2'b00;
    end else begin
      osc_s_q <= {osc_s_q[1:0], osc_i};
      ale_s_q <= {ale_s_q[0], ale_i};
      pf_s_q  <= {pf_s_q[0], power_fail_i};
    end
  end

  assign backup = pf_s_q[1];

  // Phase accumulator keeps exact 100 Hz even from a 32768 Hz crystal
  always_comb begin
    unique case (cmd_q[CMD_XTAL_HI:CMD_XTAL_LO])
      2'd0: freq = ACC_W'(F0);
      2'd1: freq = ACC_W'(F1);
      2'd2: freq = ACC_W'(F2);
      2'd3: freq = ACC_W'(F3);
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (osc_s_q[1] && !osc_s_q[2]) begin
        if (acc_q + ACC_W'(TICK_HZ) >= freq) begin
          acc_q <= acc_q + ACC_W'(TICK_HZ) - freq;
          tick  <= 1'b1;
        end else begin
          acc_q <= acc_q + ACC_W'(TICK_HZ);
        end
      end
    end
  end

  assign step = tick && cmd_q[CMD_RUN];

  // Periodic events at 100 Hz, 10 Hz, 1 s, 1 min, 1 h, 1 day
  always_comb begin
    ev           = '0;
    ev[ST_P100]  = step;
    ev[ST_P10]   = step && ((hund_q % 7'd10) == 7'd9);
    ev[ST_P1S]   = step && (hund_q >= HUND_MAX);
    ev[ST_PMIN]  = ev[ST_P1S] && (sec_q >= SEC_MAX);
    ev[ST_PHOUR] = ev[ST_PMIN] && (min_q >= MIN_MAX);
    ev[ST_PDAY]  = ev[ST_PHOUR] && (hour_q >= HOUR_MAX);
    ev[ST_ALARM] = alm_hit;
  end

  // Address latch: transparent while strobe high, so direct mode works too
  assign idx = ale_s_q[1] ? wb_adr_i[ADR_LSB +: IDX_W] : idx_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= '0;
    end else if (ale_s_q[1]) begin
      idx_q <= wb_adr_i[ADR_LSB +: IDX_W];
    end
  end

  // Bus handshake: two wait states, ack in the third request cycle, let the alarm store answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      pend_q <= wb_cyc_i && wb_stb_i && !pend_q && !ack_q;
      ack_q  <= pend_q && wb_cyc_i && wb_stb_i;
    end
  end

  assign acc_go  = pend_q && wb_cyc_i && wb_stb_i;
  assign wr_go   = acc_go && wb_we_i && wb_sel_i[0] && !backup;
  assign rd_go   = acc_go && !wb_we_i && !backup;
  assign wbyte   = wb_dat_i[7:0];
  assign st_read = rd_go && (idx == IDX_STATUS);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Time counters, host write wins over a tick in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hund_q  <= '0;
      sec_q   <= '0;
      min_q   <= '0;
      hour_q  <= '0;
      date_q  <= DATE_RST;
      month_q <= MONTH_RST;
      year_q  <= '0;
      day_q   <= '0;
    end else if (wr_go && idx <= IDX_DAY) begin
      unique case (idx[2:0])
        3'd0: hund_q  <= 7'(wbyte & field_mask(3'd0));
        3'd1: hour_q  <= from_12h(wbyte & field_mask(3'd1), cmd_q[CMD_H24]);
        3'd2: min_q   <= wbyte[5:0];
        3'd3: sec_q   <= wbyte[5:0];
        3'd4: month_q <= wbyte[3:0];
        3'd5: date_q  <= wbyte[4:0];
        3'd6: year_q  <= wbyte[6:0];
        3'd7: day_q   <= wbyte[2:0];
      endcase
    end else if (step) begin
      if (hund_q < HUND_MAX) begin
        hund_q <= hund_q + 7'd1;
      end else begin
        hund_q <= '0;
        if (sec_q < SEC_MAX) begin
          sec_q <= sec_q + 6'd1;
        end else begin
          sec_q <= '0;
          if (min_q < MIN_MAX) begin
            min_q <= min_q + 6'd1;
          end else begin
            min_q <= '0;
            if (hour_q < HOUR_MAX) begin
              hour_q <= hour_q + 5'd1;
            end else begin
              hour_q <= '0;
              day_q  <= (day_q >= DAY_MAX) ? 3'd0 : day_q + 3'd1;
              if (date_q < month_days(month_q, year_q[1:0] == 2'b00)) begin
                date_q <= date_q + 5'd1;
              end else begin
                date_q <= DATE_RST;
                if (month_q < MONTH_MAX) begin
                  month_q <= month_q + 4'd1;
                end else begin
                  month_q <= MONTH_RST;
                  year_q  <= (year_q >= YEAR_MAX) ? 7'd0 : year_q + 7'd1;
                end
              end
            end
          end
        end
      end
    end
  end

  // Live time in register layout, for snapshot and alarm compare
  always_comb begin
    live_flat        = '0;
    live_flat[6:0]   = hund_q;
    live_flat[15:8]  = to_12h(hour_q, cmd_q[CMD_H24]);
    live_flat[21:16] = min_q;
    live_flat[29:24] = sec_q;
    live_flat[35:32] = month_q;
    live_flat[44:40] = date_q;
    live_flat[54:48] = year_q;
    live_flat[58:56] = day_q;
  end

  // Snapshot taken on every hundredths read outside backup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else if (rd_go && idx == IDX_HUND) begin
      for (int i = 0; i < 8; i++) begin
        snap_q[i] <= live_flat[8*i +: 8];
      end
    end
  end

  brwa_alarm_mem u_alarm (
    .clk     (clk),
    .arst_n  (arst_n),
    .we      (wr_go && idx >= IDX_ALM0 && idx <= IDX_ALM7),
    .waddr   (idx[2:0]),
    .wdata   (wbyte & field_mask(idx[2:0])),
    .raddr   (idx[2:0]),
    .rdata_q (alm_rd),
    .flat    (alm_flat)
  );

  // Compare one cycle after a step, once the counters have moved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_q <= 1'b0;
    end else begin
      chk_q <= step;
    end
  end

  assign alm_hit = chk_q && (live_flat == alm_flat);

  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q  <= CMD_RESET;
      mask_q <= '0;
    end else if (wr_go) begin
      if (idx == IDX_CMD) begin
        cmd_q <= wbyte[CMD_W-1:0];
      end
      if (idx == IDX_MASK) begin
        mask_q <= wbyte[ST_W-1:0];
      end
    end
  end

  // Sticky status; a new event beats a read or write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((st_read ? status_q : '0) |
                   ((wr_go && idx == IDX_STATUS) ? wbyte[ST_W-1:0] : '0))) | ev;
    end
  end

  assign irq_o = |(status_q & mask_q);

  // Read mux
  always_comb begin
    rbyte = 8'h00;
    if (idx == IDX_HUND) begin
      rbyte = live_flat[7:0];
    end else if (idx <= IDX_DAY) begin
      rbyte = snap_q[idx[2:0]];
    end else if (idx <= IDX_ALM7) begin
      rbyte = alm_rd;
    end else if (idx == IDX_STATUS) begin
      rbyte = {1'b0, status_q};
    end else if (idx == IDX_MASK) begin
      rbyte = {1'b0, mask_q};
    end else if (idx == IDX_CMD) begin
      rbyte = {4'h0, cmd_q};
    end else if (idx == IDX_POWER) begin
      rbyte = {7'h00, backup};
    end
  end

  // Data lanes carry a value only in the acknowledged read cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_q <= '0;
    end else begin
      dat_q <= rd_go ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

endmodule : brwa_top

/* brwa_top_sva.sv */
// Purpose: Port checks for the bus real-time clock
// Assumes: One clock, classic Wishbone single cycles
// Notes:   Backup check waits out the pin synchroniser
`timescale 1ns/10ps
module brwa_top_sva
  import brwa_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        osc_i,
  input wire logic        ale_i,
  input wire logic        power_fail_i,
  input wire logic        irq_o
);
  logic [2:0] pf_cnt_q;
  logic [4:0] idx;
  logic       rd_ack;
  assign idx    = wb_adr_i[6:2];
  assign rd_ack = wb_ack_o && !wb_we_i;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Saturating count of cycles in backup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pf_cnt_q <= 3'h0;
    end else if (!power_fail_i) begin
      pf_cnt_q <= 3'h0;
    end else if (pf_cnt_q != 3'h7) begin
      pf_cnt_q <= pf_cnt_q + 3'h1;
    end
  end
  sequence req_rise_s;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence ack_pulse_s;
    !wb_ack_o [*2] ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_timing_a: assert property (req_rise_s |-> ack_pulse_s)
    else $error("ack timing wrong");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
    else $error("ack without request");
  read_drive_a: assert property (!rd_ack |-> wb_dat_o == 32'h0)
    else $error("data driven outside read");
  byte_lane_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("data above low byte");
  backup_mute_a: assert property (rd_ack && pf_cnt_q == 3'h7 |-> wb_dat_o == 32'h0)
    else $error("read answered in backup");
  count_range_a: assert property (
    rd_ack && (idx == IDX_HUND || idx == IDX_YEAR) |-> wb_dat_o[7:0] <= 8'h63)
    else $error("count out of range");
  unmapped_read_a: assert property (rd_ack && idx > IDX_POWER |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  irq_clear_a: assert property (
    $fell(irq_o) |-> wb_ack_o && (idx == IDX_STATUS || idx == IDX_MASK))
    else $error("irq fell without host access");
endmodule : brwa_top_sva

/* tb_bus_rtc_with_alarm.sv */
// Purpose: Self-checking bench for the bus real-time clock
// Assumes: Short crystal figures, osc rising every 8 clocks
// Notes:   A hundredth lasts F/100 osc edges
`timescale 1ns/10ps
module tb_bus_rtc_with_alarm import brwa_pkg::*;;
  typedef struct packed {logic w; logic [4:0] i; logic [7:0] d;} brwa_row_t;
  localparam int XF [4] = '{200, 400, 800, 1600};
  logic        clk, arst_n, cyc, stb, we, ack, ale, pf, irq;
  logic        osc = 1'b0;
  logic [31:0] adr, dat_w, dat_r;
  logic [3:0]  sel;
  logic [2:0]  osc_div_q = 3'h0;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  int          t0;
  brwa_row_t rows [13] = '{'{1'b0, IDX_HUND, 8'h00}, '{1'b0, IDX_MONTH, 8'h01}, '{1'b0, IDX_DATE, 8'h01},
    '{1'b1, IDX_SEC, 8'h2a}, '{1'b0, IDX_HUND, 8'h00}, '{1'b0, IDX_SEC, 8'h2a}, '{1'b1, IDX_ALM0, 8'hff},
    '{1'b0, IDX_ALM0, 8'h7f}, '{1'b1, 5'h15, 8'hff}, '{1'b0, 5'h15, 8'h00}, '{1'b0, IDX_POWER, 8'h00},
    '{1'b1, IDX_CMD, 8'h07}, '{1'b0, IDX_CMD, 8'h07}};
  // Cmd, hour, year, month, date, mask, status, then expected hour, date, month, year
  logic [7:0] cal [4][11] = '{
    '{8'h0c, 8'h17, 8'h04, 8'h02, 8'h1c, 8'h40, 8'h7e, 8'h00, 8'h1d, 8'h02, 8'h04},
    '{8'h0c, 8'h17, 8'h05, 8'h02, 8'h1c, 8'h40, 8'h7e, 8'h00, 8'h01, 8'h03, 8'h05},
    '{8'h0c, 8'h17, 8'h63, 8'h0c, 8'h1f, 8'h40, 8'h7e, 8'h00, 8'h01, 8'h01, 8'h00},
    '{8'h08, 8'h0b, 8'h01, 8'h01, 8'h01, 8'h20, 8'h3e, 8'h8c, 8'h01, 8'h01, 8'h01}};
  logic [7:0] tm [8] = '{8'h5f, 8'h05, 8'h06, 8'h07, 8'h03, 8'h04, 8'h08, 8'h02};
  brwa_top #(.F0(XF[0]), .F1(XF[1]), .F2(XF[2]), .F3(XF[3])) u_brwa_top (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .osc_i(osc), .ale_i(ale),
    .power_fail_i(pf), .irq_o(irq));
  brwa_host_model u_brwa_host_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .ale(ale));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    osc_div_q <= osc_div_q + 3'h1;
    osc       <= osc_div_q[2];
    cyc_cnt   <= cyc_cnt + 1;
  end
  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    u_brwa_host_model.access(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    logic [7:0] q;
    u_brwa_host_model.access(1'b0, i, 8'h00, q);
    check($sformatf("reg%0h", i), {8'h00, q}, {8'h00, e});
  endtask : rd
  // Bounded wait; sampled on the falling edge, clear of updates
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check("irq", {15'h0, irq}, 16'h1);
  endtask : wait_irq
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    pf     = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    check("irq_rst", {15'h0, irq}, 16'h0);
    foreach (rows[n]) begin
      if (rows[n].w) begin
        wr(rows[n].i, rows[n].d);
      end else begin
        rd(rows[n].i, rows[n].d);
      end
    end
    // Write without the low byte lane selected must store nothing
    u_brwa_host_model.set_sel(4'h0);
    wr(IDX_MASK, 8'hff);
    u_brwa_host_model.set_sel(4'h1);
    rd(IDX_MASK, 8'h00);
    foreach (cal[n]) begin
      wr(IDX_CMD, cal[n][0] & 8'hf7);
      wr(IDX_HUND, 8'h63);
      wr(IDX_SEC, 8'h3b);
      wr(IDX_MIN, 8'h3b);
      wr(IDX_HOUR, cal[n][1]);
      wr(IDX_YEAR, cal[n][2]);
      wr(IDX_MONTH, cal[n][3]);
      wr(IDX_DATE, cal[n][4]);
      wr(IDX_MASK, cal[n][5]);
      wr(IDX_STATUS, 8'h7f);
      wr(IDX_CMD, cal[n][0]);
      wait_irq();
      rd(IDX_STATUS, cal[n][6]);
      check("irq_clr", {15'h0, irq}, 16'h0);
      u_brwa_host_model.snap();
      rd(IDX_HOUR, cal[n][7]);
      rd(IDX_DATE, cal[n][8]);
      rd(IDX_MONTH, cal[n][9]);
      rd(IDX_YEAR, cal[n][10]);
    end
    // Third interval only: a crystal change upsets the first
    for (int x = 0; x < 4; x++) begin
      wr(IDX_MASK, 8'h02);
      wr(IDX_CMD, 8'h0c | 8'(x));
      wait_irq();
      wr(IDX_STATUS, 8'h02);
      wait_irq();
      t0 = cyc_cnt;
      wr(IDX_STATUS, 8'h02);
      wait_irq();
      check("tick", 16'(cyc_cnt - t0), 16'(XF[x] * 8 / 100));
    end
    wr(IDX_CMD, 8'h04);
    foreach (tm[n]) begin
      wr(5'(IDX_HUND + n), tm[n]);
      wr(5'(IDX_ALM0 + n), (n == 0) ? 8'h61 : tm[n]);
    end
    wr(IDX_MASK, 8'h01);
    wr(IDX_STATUS, 8'h7f);
    wr(IDX_CMD, 8'h0c);
    wait_irq();
    rd(IDX_STATUS, 8'h03);
    u_brwa_host_model.snap();
    repeat (100) @(posedge clk);
    rd(IDX_SEC, 8'h07);
    u_brwa_host_model.snap();
    rd(IDX_SEC, 8'h08);
    rd(IDX_DAY, 8'h02);
    u_brwa_host_model.set_ale(1'b1, IDX_MASK);
    u_brwa_host_model.set_ale(1'b0, IDX_MASK);
    rd(IDX_CMD, 8'h01);
    u_brwa_host_model.set_ale(1'b1, IDX_CMD);
    wr(IDX_MASK, 8'h02);
    pf <= 1'b1;
    repeat (8) @(posedge clk);
    rd(IDX_MASK, 8'h00);
    wr(IDX_MASK, 8'h00);
    repeat (40) @(posedge clk);
    check("irq_bak", {15'h0, irq}, 16'h1);
    pf <= 1'b0;
    repeat (8) @(posedge clk);
    rd(IDX_MASK, 8'h02);
    print_verdict();
  end
endmodule : tb_bus_rtc_with_alarm
bind brwa_top brwa_top_sva u_brwa_top_sva (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_i(osc_i), .ale_i(ale_i), .power_fail_i(power_fail_i),
  .irq_o(irq_o));
